// ===== include/event_status_pkg.sv
// Register map, field positions and shared types of the event status bank
package event_status_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] STATUS_OFF = 8'h48;
   localparam logic [7:0] MASK_OFF = 8'h4c;
   localparam logic [7:0] CTRL_OFF = 8'h50;
   localparam logic [7:0] INFO_OFF = 8'h54;
   localparam int PREJ_BIT = 1;
   localparam int DRIFT_BIT = 4;
   localparam int PIN_BIT = 5;
   localparam int DMA_DONE_BIT = 6;
   localparam int DMA_ERR_BIT = 7;
   localparam int CMD_DROP_BIT = 8;
   localparam int OVF_BIT = 9;
   localparam int UNF_BIT = 10;
   localparam int CONT_BIT = 11;
   localparam int CCA_BIT = 12;
   localparam logic [15:0] VALID_MASK = 16'h1ff2;
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam int HUNT_TIMEOUT_NS = 2000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int HUNT_CYCLES = (HUNT_TIMEOUT_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int HUNT_W = 16;
   localparam int CTRL_HUNT_LSB = 0;
   typedef struct packed {
      logic preamble_seen;
      logic preamble_confirmed;
      logic preamble_lost;
      logic supply_temp_drift;
      logic pin_irq;
      logic dma_done;
      logic dma_auth_err;
      logic dma_xfer_err;
      logic dma_addr_conflict;
      logic fast_cmd;
      logic fast_cmd_busy;
      logic fifo_overflow;
      logic fifo_underflow;
      logic contention;
      logic cca_cmd;
      logic preamble_detect;
   } event_in_t;
   typedef struct packed {
      logic start_frame_found_flag;
      logic cmd_accept;
      logic tx_start;
      logic hunting;
   } event_out_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_HUNT,
      ST_TX
   } cca_state_t;
endpackage

// ===== src/system_event_status_upper.sv
// Upper system event status register bank with assessed transmit sequencer
// What this block does
// - Writing one to bit 1 clears preamble rejection.
// - Supply or temperature drift sets bit 4.
// - Pin block interrupt sets bit 5; host queries pin block for source.
// - Writing one to bit 5 clears pin interrupt flag.
// - Crypto DMA completion sets bit 6; writing one clears it.
// - Authentication, transfer or address conflict error sets bit 7.
// - Writing one to bit 7 clears crypto DMA error.
// - Fast command while previous busy is discarded and sets bit 8.
// - Host receive FIFO overflow sets bit 9.
// - Host transmit FIFO underflow sets bit 10.
// - Failed host transaction from internal contention sets bit 11.
// - Assessed transmit hunts preamble, transmits after hunt timeout.
// - Preamble found during hunt: no transmit, idle, set bit 12.
// - Writing one to bit 12 clears channel-busy failure.
`timescale 1ns/1ps
module system_event_status_upper #(
   parameter int HUNT_DEFAULT = event_status_pkg::HUNT_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire event_status_pkg::event_in_t ev,
   output event_status_pkg::event_out_t evo
);
   logic [15:0] status_q;
   logic [15:0] status_d;
   logic [15:0] mask_q;
   localparam int HUNT_W_L = event_status_pkg::HUNT_W;
   logic [HUNT_W_L-1:0] hunt_len_q;
   logic [HUNT_W_L-1:0] hunt_cnt_q;
   logic ack_q;
   logic [15:0] set_v;
   logic [15:0] clr_v;
   logic wr_fire;
   logic rd_fire;
   logic cmd_busy_q;
   logic sfd_q;
   logic channel_busy_abort_ev;
   logic cca_tx_ev;
   event_status_pkg::cca_state_t state_q;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction

   // One wait state: the answer comes on the edge after the request
   assign wr_fire = avs_write && ack_q;
   assign rd_fire = avs_read && ack_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
      end
   end

   // Event collection
   always_comb begin
      set_v = 16'h0000;
      set_v[event_status_pkg::PREJ_BIT] = ev.preamble_seen
         && ev.preamble_lost && !ev.preamble_confirmed;
      set_v[event_status_pkg::DRIFT_BIT] = ev.supply_temp_drift;
      set_v[event_status_pkg::PIN_BIT] = ev.pin_irq;
      set_v[event_status_pkg::DMA_DONE_BIT] = ev.dma_done;
      set_v[event_status_pkg::DMA_ERR_BIT] = ev.dma_auth_err
         || ev.dma_xfer_err || ev.dma_addr_conflict;
      set_v[event_status_pkg::CMD_DROP_BIT] = ev.fast_cmd
         && (ev.fast_cmd_busy || cmd_busy_q);
      set_v[event_status_pkg::OVF_BIT] = ev.fifo_overflow;
      set_v[event_status_pkg::UNF_BIT] = ev.fifo_underflow;
      set_v[event_status_pkg::CONT_BIT] = ev.contention;
      set_v[event_status_pkg::CCA_BIT] = channel_busy_abort_ev;
   end

   // Write-one-to-clear, set wins, reserved stay zero
   always_comb begin
      clr_v = 16'h0000;
      if (wr_fire && hit(avs_address, event_status_pkg::STATUS_OFF)) begin
         clr_v[7:0] = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
         clr_v[15:8] = avs_byteenable[1] ? avs_writedata[15:8] : 8'h00;
      end
      status_d = ((status_q & ~clr_v) | set_v)
         & event_status_pkg::VALID_MASK;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         status_q <= event_status_pkg::STATUS_RST;
      end else begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mask_q <= event_status_pkg::MASK_RST;
         hunt_len_q <= HUNT_W_L'(HUNT_DEFAULT);
      end else if (wr_fire) begin
         if (hit(avs_address, event_status_pkg::MASK_OFF)) begin
            if (avs_byteenable[0]) begin
               mask_q[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
               mask_q[15:8] <= avs_writedata[15:8];
            end
         end
         if (hit(avs_address, event_status_pkg::CTRL_OFF)) begin
            if (avs_byteenable[0]) begin
               hunt_len_q[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
               hunt_len_q[15:8] <= avs_writedata[15:8];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_d & mask_q);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if ((avs_read && !ack_q)) begin
         if (hit(avs_address, event_status_pkg::STATUS_OFF)) begin
            avs_readdata <= {16'h0000, status_q};
         end else if (hit(avs_address, event_status_pkg::MASK_OFF)) begin
            avs_readdata <= {16'h0000, mask_q};
         end else if (hit(avs_address, event_status_pkg::CTRL_OFF)) begin
            avs_readdata <= {16'h0000, hunt_len_q};
         end else if (hit(avs_address, event_status_pkg::INFO_OFF)) begin
            avs_readdata <= {28'h0000000, sfd_q, cmd_busy_q,
                             state_q};
         end else begin
            avs_readdata <= 32'h0000_0000;
         end
      end
   end

   // Start-frame flag only after preamble confirmation
   always_ff @(posedge clk) begin
      if (rst) begin
         sfd_q <= 1'b0;
      end else if (ev.preamble_seen && ev.preamble_confirmed) begin
         sfd_q <= 1'b1;
      end else if (ev.preamble_seen || ev.preamble_lost) begin
         sfd_q <= 1'b0;
      end
   end

   // Fast command acceptance; held busy one cycle after accepting
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_busy_q <= 1'b0;
      end else begin
         cmd_busy_q <= ev.fast_cmd && !ev.fast_cmd_busy && !cmd_busy_q;
      end
   end

   // Assessed transmit sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= event_status_pkg::ST_IDLE;
         hunt_cnt_q <= '0;
      end else begin
         case (state_q)
            event_status_pkg::ST_IDLE: begin
               if (ev.cca_cmd) begin
                  state_q <= event_status_pkg::ST_HUNT;
                  hunt_cnt_q <= '0;
               end
            end
            event_status_pkg::ST_HUNT: begin
               if (ev.preamble_detect) begin
                  state_q <= event_status_pkg::ST_IDLE;
               end else if (hunt_cnt_q >= hunt_len_q - 16'h0001) begin
                  state_q <= event_status_pkg::ST_TX;
               end else begin
                  hunt_cnt_q <= hunt_cnt_q + 16'h0001;
               end
            end
            event_status_pkg::ST_TX: begin
               state_q <= event_status_pkg::ST_IDLE;
            end
            default: begin
               state_q <= event_status_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign channel_busy_abort_ev = (state_q == event_status_pkg::ST_HUNT)
      && ev.preamble_detect;
   assign cca_tx_ev = (state_q == event_status_pkg::ST_TX);

   always_ff @(posedge clk) begin
      if (rst) begin
         evo <= '0;
      end else begin
         evo.start_frame_found_flag <= sfd_q;
         evo.cmd_accept <= cmd_busy_q;
         evo.tx_start <= cca_tx_ev;
         evo.hunting <= (state_q == event_status_pkg::ST_HUNT);
      end
   end

   // Cycles spent hunting, so the hunt length can be checked
   logic [HUNT_W_L-1:0] hunt_age_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         hunt_age_q <= '0;
      end else if (state_q == event_status_pkg::ST_HUNT) begin
         hunt_age_q <= hunt_age_q + 16'h0001;
      end else begin
         hunt_age_q <= '0;
      end
   end

   // Event flags and sequencer
   a_preject_sets: assert property (@(posedge clk) disable iff (rst)
      set_v[1] |=> status_q[1])
      else $error("preamble reject not latched");
   a_reject_no_sfd: assert property (@(posedge clk) disable iff (rst)
      set_v[1] |=> !sfd_q)
      else $error("start frame flag set on rejected preamble");
   a_confirm_sfd: assert property (@(posedge clk) disable iff (rst)
      (ev.preamble_seen && ev.preamble_confirmed) |=> sfd_q)
      else $error("start frame flag missing after confirmation");
   a_prej_clear: assert property (@(posedge clk) disable iff (rst)
      (clr_v[1] && !set_v[1]) |=> !status_q[1])
      else $error("preamble reject not cleared by one");
   a_drift_set: assert property (@(posedge clk) disable iff (rst)
      ev.supply_temp_drift |=> status_q[4])
      else $error("drift flag not latched");
   a_pin_set: assert property (@(posedge clk) disable iff (rst)
      ev.pin_irq |=> status_q[5])
      else $error("pin flag not latched");
   a_w1c_clears: assert property (@(posedge clk) disable iff (rst)
      (clr_v[5] && !set_v[5]) |=> !status_q[5])
      else $error("pin flag not cleared by one");
   a_dma_done_set: assert property (@(posedge clk) disable iff (rst)
      ev.dma_done |=> status_q[6])
      else $error("dma completion not latched");
   a_dma_err_set: assert property (@(posedge clk) disable iff (rst)
      (ev.dma_auth_err || ev.dma_xfer_err || ev.dma_addr_conflict)
      |=> status_q[7])
      else $error("dma error not latched");
   a_dma_err_clr: assert property (@(posedge clk) disable iff (rst)
      (clr_v[7] && !set_v[7]) |=> !status_q[7])
      else $error("dma error not cleared by one");
   a_drop_cmd: assert property (@(posedge clk) disable iff (rst)
      (ev.fast_cmd && ev.fast_cmd_busy) |=> status_q[8] && !cmd_busy_q)
      else $error("busy command not dropped");
   a_back_cmd: assert property (@(posedge clk) disable iff (rst)
      (ev.fast_cmd && cmd_busy_q) |=> status_q[8] && !cmd_busy_q)
      else $error("back to back command not dropped");
   a_cmd_accept: assert property (@(posedge clk) disable iff (rst)
      (ev.fast_cmd && !ev.fast_cmd_busy && !cmd_busy_q) |=> cmd_busy_q)
      else $error("idle command not accepted");
   a_ovf_set: assert property (@(posedge clk) disable iff (rst)
      ev.fifo_overflow |=> status_q[9])
      else $error("overflow flag not latched");
   a_unf_set: assert property (@(posedge clk) disable iff (rst)
      ev.fifo_underflow |=> status_q[10])
      else $error("underflow flag not latched");
   a_cont_set: assert property (@(posedge clk) disable iff (rst)
      ev.contention |=> status_q[11])
      else $error("contention flag not latched");
   a_hunt_enter: assert property (@(posedge clk) disable iff (rst)
      (state_q == event_status_pkg::ST_IDLE && ev.cca_cmd)
      |=> state_q == event_status_pkg::ST_HUNT)
      else $error("assessed transmit did not start hunting");
   a_hunt_tx: assert property (@(posedge clk) disable iff (rst)
      $rose(cca_tx_ev) |-> $past(state_q) == event_status_pkg::ST_HUNT
      && !$past(ev.preamble_detect))
      else $error("transmit without clean hunt");
   a_hunt_time: assert property (@(posedge clk) disable iff (rst)
      ($rose(cca_tx_ev) && $stable(hunt_len_q)) |-> hunt_age_q == hunt_len_q)
      else $error("transmit not after full hunt length");
   a_channel_busy_abort: assert property (@(posedge clk) disable iff (rst)
      channel_busy_abort_ev |=> (state_q == event_status_pkg::ST_IDLE)
      && status_q[12] ##1 !evo.tx_start)
      else $error("channel busy handling wrong");
   a_cca_clear: assert property (@(posedge clk) disable iff (rst)
      (clr_v[12] && !set_v[12]) |=> !status_q[12])
      else $error("channel busy flag not cleared by one");
   // Sticky behaviour and reserved bits
   a_sticky_hold: assert property (@(posedge clk) disable iff (rst)
      (status_q[6] && !clr_v[6]) |=> status_q[6])
      else $error("flag lost without clear");
   a_set_wins: assert property (@(posedge clk) disable iff (rst)
      (set_v[9] && clr_v[9]) |=> status_q[9])
      else $error("clear beat a new event");
   a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      (status_q & ~event_status_pkg::VALID_MASK) == 16'h0000)
      else $error("reserved bit set");

   // Bus handshake and interrupt
   a_wait_one: assert property (@(posedge clk) disable iff (rst)
      ((avs_read || avs_write) && !ack_q) |=> !avs_waitrequest)
      else $error("request not answered after one wait state");
   a_wait_single: assert property (@(posedge clk) disable iff (rst)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("answer held longer than one cycle");
   a_upper_zero: assert property (@(posedge clk) disable iff (rst)
      avs_readdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_irq_level: assert property (@(posedge clk) disable iff (rst)
      $stable(mask_q) |-> irq == |(status_q & mask_q))
      else $error("interrupt mismatch");

   c_channel_busy_abort: cover property (@(posedge clk) disable iff (rst)
      channel_busy_abort_ev);
   c_cca_tx: cover property (@(posedge clk) disable iff (rst) cca_tx_ev);
   c_set_clear_same: cover property (@(posedge clk) disable iff (rst)
      set_v[9] && clr_v[9]);
   c_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));
endmodule

// ===== dv/host_model.sv
// Avalon-MM host master that reads and clears the event flags
`timescale 1ns/1ps
module host_model (
   input wire logic clk,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h3;
   end
   // Holds the request until waitrequest is sampled low
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [15:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
endmodule

// ===== dv/system_event_status_upper_tb.sv
// Register-level bench for the upper event status bank
`timescale 1ns/1ps
module system_event_status_upper_tb;
   localparam int HUNT = 4;
   localparam logic [7:0] ST = event_status_pkg::STATUS_OFF;
   localparam logic [7:0] MK = event_status_pkg::MASK_OFF;
   logic clk;
   logic rst;
   logic [7:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   event_status_pkg::event_in_t ev;
   event_status_pkg::event_out_t evo;
   int failures = 0;
   int comparisons = 0;
   int accepts = 0;
   int txs = 0;
   logic [31:0] q;
   logic [15:0] m;
   logic [15:0] evt [11] = '{16'ha000, 16'h1000, 16'h0800, 16'h0400,
      16'h0200, 16'h0100, 16'h0080, 16'h0060, 16'h0010, 16'h0008, 16'h0004};
   int bn [11] = '{1, 4, 5, 6, 7, 7, 7, 8, 9, 10, 11};
   system_event_status_upper #(.HUNT_DEFAULT(HUNT)) u_dut (
      .clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq(irq), .ev(ev), .evo(evo));
   host_model u_host (
      .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (evo.cmd_accept === 1'b1) accepts++;
      if (evo.tx_start === 1'b1) txs++;
   end
   task automatic chk(input string n, input logic [31:0] s,
      input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] t;
      u_host.xfer(1'b1, a, d, t);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      u_host.xfer(1'b0, a, 16'h0000, r);
   endtask
   task automatic pulse(input logic [15:0] v);
      ev <= event_status_pkg::event_in_t'(v);
      @(posedge clk);
      ev <= '0;
      repeat (2) @(posedge clk);
   endtask
   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      finish_test();
   end
   initial begin
      rst = 1'b1;
      ev = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(ST, q);
      chk("status rst", q, 32'h00000000);
      rd(MK, q);
      chk("mask rst", q, 32'h00000000);
      rd(event_status_pkg::CTRL_OFF, q);
      chk("hunt len", q, HUNT);
      wr(8'h60, 16'hffff);
      rd(8'h60, q);
      chk("unmapped", q, 32'h00000000);
      $display("test reset done");
      for (int i = 0; i < 11; i++) begin
         m = 16'h0001 << bn[i];
         pulse(evt[i]);
         rd(ST, q);
         chk("set", q, {16'h0000, m});
         chk("sfd", {31'h0, evo.start_frame_found_flag}, 32'h0);
         wr(ST, ~m);
         rd(ST, q);
         chk("keep", q, {16'h0000, m});
         wr(ST, m);
         rd(ST, q);
         chk("clear", q, 32'h00000000);
      end
      chk("dropped", accepts, 0);
      $display("test events done");
      pulse(16'hc000);
      pulse(16'h0040);
      rd(ST, q);
      chk("no reject", q, 32'h00000000);
      chk("accepted", accepts, 1);
      $display("test accepted done");
      pulse(16'h0002);
      chk("hunting", {31'h0, evo.hunting}, 32'h1);
      repeat (HUNT + 10) @(posedge clk);
      chk("cca tx", txs, 1);
      rd(ST, q);
      chk("cca ok", q, 32'h00000000);
      ev <= 16'h0002;
      @(posedge clk);
      ev <= 16'h0001;
      @(posedge clk);
      ev <= '0;
      repeat (HUNT + 10) @(posedge clk);
      chk("cca busy tx", txs, 1);
      chk("idle", {31'h0, evo.hunting}, 32'h0);
      rd(ST, q);
      chk("channel_busy_abort", q, 32'h00001000);
      pulse(16'hbffc);
      rd(ST, q);
      chk("all", q, {16'h0000, event_status_pkg::VALID_MASK});
      wr(ST, 16'hffff);
      rd(ST, q);
      chk("all clear", q, 32'h00000000);
      $display("test assessed transmit done");
      wr(MK, 16'h0010);
      rd(MK, q);
      chk("mask", q, 32'h00000010);
      pulse(16'h0800);
      repeat (2) @(posedge clk);
      chk("masked irq", {31'h0, irq}, 32'h0);
      pulse(16'h1000);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(ST, 16'h0010);
      repeat (2) @(posedge clk);
      chk("irq clear", {31'h0, irq}, 32'h0);
      rd(ST, q);
      chk("pin left", q, 32'h00000020);
      wr(ST, 16'h0020);
      $display("test interrupt done");
      finish_test();
   end
endmodule
